// File: hw/asrc_pkg.sv
/*
 Constants for the scan and reference control block of a small
 multichannel 8-bit converter. Assumes a 32-bit classic Wishbone
 register bus and one converter core on its own link clock.
*/
`default_nettype none
package asrc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_RESULT = 8'h0c;
  // Config fields
  localparam int CFG_SCAN_LSB = 0;
  localparam int CFG_CH_LSB = 2;
  localparam int CFG_SGL_BIT = 6;
  localparam int CFG_BIP_BIT = 7;
  localparam int CFG_EXT_BIT = 8;
  localparam int CFG_REF_LSB = 9;
  localparam int CFG_W = 12;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  // Scan codes
  localparam logic [1:0] SCAN_UP = 2'h0;
  localparam logic [1:0] SCAN_REPEAT = 2'h1;
  localparam logic [1:0] SCAN_MID = 2'h2;
  localparam logic [1:0] SCAN_ONCE = 2'h3;
  localparam logic [2:0] REPEAT_LAST = 3'h7;
  localparam logic [3:0] MID_BASE_FOUR = 4'h2;
  localparam logic [3:0] MID_BASE_TWELVE = 4'h6;
  localparam logic [7:0] BIPOLAR_FLIP = 8'h80;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} asrc_state_e;
endpackage : asrc_pkg
`default_nettype wire

// File: hw/asrc_control.sv
/*
 Scan sequencer, reference decode, result queue and Wishbone slave.
 Assumes a converter core clocked by link_clk that starts on conv_start
 and answers with conv_done and an offset-binary sample.
*/
`default_nettype none
module asrc_control
  import asrc_pkg::*;
#(
  parameter int NUM_INPUTS = 12,
  parameter int QUEUE_DEPTH = 16
)
(
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Reference control
  output logic ref_from_supply,
  output logic ref_from_external,
  output logic ref_internal,
  output logic internal_ref_on,
  output logic shared_pin_ref_in,
  output logic shared_pin_ref_out,
  // Converter link
  input wire logic link_clk,
  output logic conv_start,
  output logic [3:0] conv_pos_ch,
  output logic [3:0] conv_neg_ch,
  output logic conv_diff,
  input wire logic conv_done,
  input wire logic [7:0] conv_data
);
  localparam bit FOUR = (NUM_INPUTS == 4);
  localparam int QW = $clog2(QUEUE_DEPTH);

  // Bus decode
  logic ack_r;
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i;
  wire sel_cfg = wb_adr_i == ADR_CONFIG;
  wire sel_ctrl = wb_adr_i == ADR_CTRL;
  wire sel_stat = wb_adr_i == ADR_STATUS;
  wire sel_res = wb_adr_i == ADR_RESULT;
  wire ctrl_wr = bus_wr & sel_ctrl & wb_sel_i[0];
  wire start_wr = ctrl_wr & wb_dat_i[CTRL_START_BIT];
  wire stop_wr = ctrl_wr & wb_dat_i[CTRL_STOP_BIT];

  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (bus_wr && sel_cfg && wb_sel_i[0])
      cfg_nxt[7:0] = wb_dat_i[7:0];
    if (bus_wr && sel_cfg && wb_sel_i[1])
      cfg_nxt[CFG_W-1:8] = wb_dat_i[CFG_W-1:8];
  end

  // Config fields
  wire [1:0] scan_sel = cfg_r[CFG_SCAN_LSB +: 2];
  wire [3:0] ch_raw = cfg_r[CFG_CH_LSB +: 4];
  wire [3:0] ch_sel = FOUR ? {2'h0, ch_raw[1:0]} : ch_raw;
  wire sgl = cfg_r[CFG_SGL_BIT];
  wire bip = cfg_r[CFG_BIP_BIT];
  wire ext = cfg_r[CFG_EXT_BIT];
  wire [2:0] ref_sel = cfg_r[CFG_REF_LSB +: 3];

  // Scan bounds, taken when a scan starts
  wire [3:0] mid_base = FOUR ? MID_BASE_FOUR : MID_BASE_TWELVE;
  wire multi = ~scan_sel[0];
  wire pair_step = multi & ~sgl;
  wire [3:0] up_first = pair_step ? {3'h0, ch_sel[0]} : 4'h0;
  wire [3:0] mid_first = pair_step ? {mid_base[3:1], ch_sel[0]}
                                   : mid_base;
  wire [3:0] start_ch = (scan_sel == SCAN_UP) ? up_first :
                        (scan_sel == SCAN_MID) ? mid_first : ch_sel;
  // Low selections still end the upper scan at its base
  wire [3:0] end_ch = (scan_sel == SCAN_MID && ch_sel < mid_first)
                      ? mid_first : ch_sel;

  asrc_state_e st_r;
  asrc_state_e st_nxt;
  logic [1:0] mode_r;
  logic ext_r, step2_r, bip_r, stop_r, req_tog_r, dif_r;
  logic [3:0] cur_r, last_r;
  logic [2:0] rep_r;
  logic q_full, q_empty;
  logic ack_evt;
  logic [7:0] lk_data_r;

  wire load = (st_r == ST_IDLE) & start_wr;
  // External clock makes 01 and 11 an open-ended stream
  wire endless = ext_r & mode_r[0];
  wire [4:0] nxt_ch = {1'b0, cur_r} + (step2_r ? 5'h02 : 5'h01);
  wire seq_last = endless ? 1'b0 :
                  (mode_r == SCAN_REPEAT) ? (rep_r == REPEAT_LAST) :
                  (mode_r == SCAN_ONCE) ? 1'b1 :
                  (nxt_ch > {1'b0, last_r});
  wire done_now = (st_r == ST_WAIT) & ack_evt;
  wire issue = (st_r == ST_ISSUE) & ~stop_r & ~q_full;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE:
        if (start_wr)
          st_nxt = ST_ISSUE;
      ST_ISSUE:
        if (stop_r)
          st_nxt = ST_IDLE;
        else if (!q_full)
          st_nxt = ST_WAIT;
      ST_WAIT:
        if (ack_evt)
          st_nxt = (seq_last | stop_r) ? ST_IDLE : ST_ISSUE;
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  wire busy = st_r != ST_IDLE;
  // Stop request set wins over its clearing on return to idle
  wire stop_nxt = stop_wr | (stop_r & busy);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg_r <= CFG_RESET;
      st_r <= ST_IDLE;
      stop_r <= 1'b0;
      req_tog_r <= 1'b0;
      ack_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      st_r <= st_nxt;
      stop_r <= stop_nxt;
      req_tog_r <= req_tog_r ^ issue;
      ack_r <= bus_req;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mode_r <= SCAN_UP;
      {ext_r, step2_r, bip_r, dif_r} <= 4'h0;
      cur_r <= 4'h0;
      last_r <= 4'h0;
      rep_r <= 3'h0;
    end
    else if (load)
    begin
      mode_r <= scan_sel;
      {ext_r, step2_r, bip_r, dif_r} <= {ext, pair_step, bip, ~sgl};
      cur_r <= start_ch;
      last_r <= end_ch;
      rep_r <= 3'h0;
    end
    else if (done_now && !seq_last && mode_r == SCAN_UP || done_now
             && !seq_last && mode_r == SCAN_MID)
      cur_r <= nxt_ch[3:0];
    else if (done_now)
      rep_r <= rep_r + 3'h1;
  end

  // Reference decode, registered
  wire ref_always_on = ref_sel[2] & (ref_sel[1] | ref_sel[0]);
  wire ref_auto = ref_sel[2] & ~ref_sel[1] & ~ref_sel[0];
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      {ref_from_supply, ref_from_external, ref_internal} <= 3'h4;
      {internal_ref_on, shared_pin_ref_in, shared_pin_ref_out} <= 3'h0;
    end
    else
    begin
      ref_from_supply <= ~ref_sel[2] & ~ref_sel[1];
      ref_from_external <= ~ref_sel[2] & ref_sel[1];
      ref_internal <= ref_sel[2];
      // Auto-off reference is powered only while a scan runs
      internal_ref_on <= ref_always_on | (ref_auto & busy);
      shared_pin_ref_in <= ~ref_sel[2] & ref_sel[1];
      shared_pin_ref_out <= ref_sel[2] & ref_sel[1];
    end
  end

  // Result queue
  logic [11:0] q_mem [QUEUE_DEPTH];
  logic [QW:0] wp_r, rp_r;
  wire [QW:0] q_count = wp_r - rp_r;
  assign q_full = q_count == QUEUE_DEPTH[QW:0];
  assign q_empty = q_count == '0;
  wire [11:0] q_head = q_mem[rp_r[QW-1:0]];
  wire [7:0] res_data = bip_r ? (lk_data_r ^ BIPOLAR_FLIP) : lk_data_r;
  wire pop = bus_req & ~wb_we_i & sel_res & ~q_empty;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_r + {{QW{1'b0}}, done_now};
      rp_r <= rp_r + {{QW{1'b0}}, pop};
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (done_now)
      q_mem[wp_r[QW-1:0]] <= {cur_r, res_data};
  end

  // Read data
  wire [31:0] rd_cfg = {{(32-CFG_W){1'b0}}, cfg_r};
  wire [31:0] rd_stat = {16'h0000, {(8-QW-1){1'b0}}, q_count, 7'h00, busy};
  wire [31:0] rd_res = {15'h0000, ~q_empty, 4'h0, q_head};
  wire [31:0] rdata = sel_cfg ? rd_cfg : sel_stat ? rd_stat :
                      sel_res ? rd_res : 32'h0000_0000;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req)
      wb_dat_o <= rdata;
  end
  assign wb_ack_o = ack_r;

  // Link side: reset and request crossing, three stages each
  logic lr1, lr2, lr3, lrst_r;
  logic q1, q2, q3, seen_r, lbusy_r, ack_tog_r;
  always_ff @(posedge link_clk)
  begin
    {lr1, lr2, lr3} <= {sys_rst, lr1, lr2};
    if (lr2 == lr3)
      lrst_r <= lr3;
  end
  wire req_evt = (q2 == q3) & (q3 != seen_r);
  always_ff @(posedge link_clk)
  begin
    if (lrst_r)
    begin
      {q1, q2, q3, seen_r} <= 4'h0;
      {lbusy_r, ack_tog_r, conv_start, conv_diff} <= 4'h0;
      conv_pos_ch <= 4'h0;
      conv_neg_ch <= 4'h0;
      lk_data_r <= 8'h00;
    end
    else
    begin
      {q1, q2, q3} <= {req_tog_r, q1, q2};
      conv_start <= req_evt & ~lbusy_r;
      if (req_evt && !lbusy_r)
      begin
        // Sys holds these steady for the whole handshake
        seen_r <= q3;
        lbusy_r <= 1'b1;
        conv_pos_ch <= cur_r;
        conv_neg_ch <= cur_r ^ 4'h1;
        conv_diff <= dif_r;
      end
      else if (lbusy_r && conv_done)
      begin
        lk_data_r <= conv_data;
        lbusy_r <= 1'b0;
        ack_tog_r <= ~ack_tog_r;
      end
    end
  end

  // Answer crossing back to sys
  logic a1, a2, a3, aseen_r;
  assign ack_evt = (a2 == a3) & (a3 != aseen_r);
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      {a1, a2, a3, aseen_r} <= 4'h0;
    else
    begin
      {a1, a2, a3} <= {ack_tog_r, a1, a2};
      if (ack_evt)
        aseen_r <= a3;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [3:0] run_cnt_r;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || load)
      run_cnt_r <= 4'h0;
    else if (done_now)
      run_cnt_r <= run_cnt_r + 4'h1;
  end

  scan_up_first_a: assert property (
    load && scan_sel == SCAN_UP && sgl |=> cur_r == 4'h0)
    else $error("upward scan did not start at input zero");
  repeat_eight_a: assert property (
    done_now && mode_r == SCAN_REPEAT && !ext_r && !stop_r
    |-> seq_last == (run_cnt_r == 4'h7))
    else $error("repeat mode did not end after eight conversions");
  mid_four_a: assert property (
    FOUR && load && scan_sel == SCAN_MID && sgl
    |=> cur_r == 4'h2 && last_r >= 4'h2)
    else $error("four-input upper scan base wrong");
  mid_twelve_a: assert property (
    !FOUR && load && scan_sel == SCAN_MID && sgl
    |=> cur_r == 4'h6 && last_r >= 4'h6)
    else $error("twelve-input upper scan base wrong");
  once_stop_a: assert property (
    done_now && mode_r == SCAN_ONCE && !ext_r |=> st_r == ST_IDLE)
    else $error("single conversion mode did not stop");
  stream_keep_a: assert property (
    done_now && endless && !stop_r |=> st_r == ST_ISSUE)
    else $error("external clock stream ended without stop");
  ref_out_on_a: assert property (
    ref_sel[2] && ref_sel[1] ##1 ref_sel[2] && ref_sel[1]
    |=> internal_ref_on && shared_pin_ref_out && !ref_from_supply)
    else $error("reference output decode wrong");
  bipolar_fmt_a: assert property (
    done_now |=> q_mem[$past(wp_r[QW-1:0])][7] ==
    ($past(lk_data_r[7]) ^ $past(bip_r)))
    else $error("result coding wrong");
  pair_parity_a: assert property (
    load && pair_step |=> cur_r[0] == $past(ch_sel[0]) && step2_r)
    else $error("pseudo-differential pairing parity wrong");
  upper_zero_a: assert property (
    FOUR && busy |-> cur_r[3:2] == 2'h0 && last_r[3:2] == 2'h0)
    else $error("upper channel bits not forced to zero");
  queue_order_a: assert property (
    pop |=> wb_dat_o[11:0] == $past(q_head) && wb_dat_o[16])
    else $error("result queue order wrong");

  cov_repeat_c: cover property (
    done_now && mode_r == SCAN_REPEAT && seq_last);
  cov_mid_c: cover property (done_now && mode_r == SCAN_MID && seq_last);
  cov_stream_stop_c: cover property (endless && stop_r ##1 !busy);
  cov_full_c: cover property (st_r == ST_ISSUE && q_full);
endmodule : asrc_control
`default_nettype wire

// File: sim/asrc_conv_model.sv
/*
 Behavioural converter core on the link clock.
 Assumes one conv_start pulse per conversion from the control block.
*/
`default_nettype none
module asrc_conv_model
(
  // Link
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic conv_start,
  input wire logic [3:0] conv_pos_ch,
  // Test control
  input wire logic slow,
  // Answer
  output logic conv_done,
  output logic [7:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ch_r;
  logic [3:0] cnt_r;
  logic busy_r;
  // Sample is {channel, 5}; data scrambled outside done
  always_ff @(posedge link_clk)
  begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (sys_rst)
    begin
      busy_r <= 1'b0;
      conv_data <= 8'h00;
    end
    else if (conv_start)
    begin
      busy_r <= 1'b1;
      ch_r <= conv_pos_ch;
      cnt_r <= slow ? 4'h9 : 4'h2;
    end
    else if (busy_r && cnt_r == 4'h0)
    begin
      busy_r <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= {ch_r, 4'h5};
    end
    else if (busy_r)
      cnt_r <= cnt_r - 4'h1;
  end
endmodule : asrc_conv_model
`default_nettype wire

// File: sim/tb_top.sv
/*
 Self-checking bench: Wishbone tasks, scans, stream stop, references.
 Assumes asrc_control and the converter model beside it.
*/
`default_nettype none
module tb_top
  import asrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, sys_rst, link_clk, cyc, stb, we, ack, slow;
  logic [7:0] adr;
  logic [31:0] wdat, dat_o, rdat;
  wire [5:0] ref_v;
  logic [31:0] dat4, rdat4;
  logic conv_start4, conv_done4;
  logic [3:0] pos_ch4;
  logic [7:0] conv_data4;
  logic conv_start, conv_diff, conv_done;
  logic [3:0] pos_ch, neg_ch;
  logic [7:0] conv_data;
  int bad_count, checks, cycles;
  initial
  begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    link_clk = 0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  asrc_control dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ref_from_supply(ref_v[5]), .ref_from_external(ref_v[4]),
    .ref_internal(ref_v[3]), .internal_ref_on(ref_v[2]),
    .shared_pin_ref_in(ref_v[1]), .shared_pin_ref_out(ref_v[0]),
    .link_clk(link_clk), .conv_start(conv_start), .conv_pos_ch(pos_ch),
    .conv_neg_ch(neg_ch), .conv_diff(conv_diff), .conv_done(conv_done),
    .conv_data(conv_data));
  asrc_conv_model model_u (.link_clk(link_clk), .sys_rst(sys_rst),
    .conv_start(conv_start), .conv_pos_ch(pos_ch), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));
  // Four-input variant in lockstep on the same bus, own read data
  asrc_control #(.NUM_INPUTS(4)) dut4_u (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat4),
    .wb_ack_o(), .ref_from_supply(), .ref_from_external(),
    .ref_internal(), .internal_ref_on(), .shared_pin_ref_in(),
    .shared_pin_ref_out(), .link_clk(link_clk),
    .conv_start(conv_start4), .conv_pos_ch(pos_ch4), .conv_neg_ch(),
    .conv_diff(), .conv_done(conv_done4), .conv_data(conv_data4));
  asrc_conv_model model4_u (.link_clk(link_clk), .sys_rst(sys_rst),
    .conv_start(conv_start4), .conv_pos_ch(pos_ch4), .slow(slow),
    .conv_done(conv_done4), .conv_data(conv_data4));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Master holds everything until the edge that samples ack
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rdat = dat_o;
    rdat4 = dat4;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : acc
  task automatic wait_idle;
    do acc(1'b0, ADR_STATUS, 32'h0); while (rdat[0] !== 1'b0);
  endtask : wait_idle
  function automatic logic [31:0] cfg(input logic [1:0] s,
    input logic [3:0] ch, input logic sgl, bip, ext, input logic [2:0] r);
    return {20'h0, r, ext, bip, sgl, ch, s};
  endfunction : cfg
  task automatic pop(input logic [3:0] ch, input logic bip);
    acc(1'b0, ADR_RESULT, 32'h0);
    chk(rdat, {15'h0, 1'b1, 4'h0, ch, ch ^ {bip, 3'h0}, 4'h5});
  endtask : pop
  task automatic run_scan(input logic [31:0] c, input int first,
    input int step, input int n, input logic bip);
    acc(1'b1, ADR_CONFIG, c);
    acc(1'b1, ADR_CTRL, 32'h1);
    wait_idle();
    for (int k = 0; k < n; k++)
      pop(4'(first + k * step), bip);
    // Empty queue answers invalid
    acc(1'b0, ADR_RESULT, 32'h0);
    chk(32'(rdat[16]), 32'h0);
    $display("scan test done, config %h", c);
  endtask : run_scan
  // Same upper scan on both variants; upper channel bits masked on four
  task automatic run_pair(input logic [3:0] ch, input int f4,
    input int f12, input int n);
    acc(1'b1, ADR_CONFIG, cfg(SCAN_MID, ch, 1, 0, 0, 0));
    acc(1'b1, ADR_CTRL, 32'h1);
    wait_idle();
    for (int k = 0; k < n; k++)
    begin
      acc(1'b0, ADR_RESULT, 32'h0);
      chk(rdat4, {15'h0, 1'b1, 4'h0, 4'(f4 + k), 4'(f4 + k), 4'h5});
      chk(rdat, {15'h0, 1'b1, 4'h0, 4'(f12 + k), 4'(f12 + k), 4'h5});
    end
    acc(1'b0, ADR_RESULT, 32'h0);
    chk(32'(rdat4[16]), 32'h0);
    $display("four-input test done, channel %h", ch);
  endtask : run_pair
  initial
  begin
    logic [2:0] e;
    logic [7:0] n;
    {cyc, stb, we, slow, adr, wdat} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(32'(ref_v), 32'h20);
    acc(1'b1, 8'h10, 32'hffffffff);
    acc(1'b0, 8'h10, 32'h0);
    chk(rdat, 32'h0);
    acc(1'b0, ADR_CONFIG, 32'h0);
    chk(rdat, 32'h0);
    $display("reset test done");
    run_scan(cfg(SCAN_UP, 4'h3, 1, 0, 0, 0), 0, 1, 4, 0);
    run_scan(cfg(SCAN_REPEAT, 4'h5, 1, 0, 0, 0), 5, 0, 8, 0);
    slow <= 1'b1;
    run_scan(cfg(SCAN_MID, 4'h9, 1, 0, 0, 0), 6, 1, 4, 0);
    slow <= 1'b0;
    run_scan(cfg(SCAN_MID, 4'h2, 1, 0, 0, 0), 6, 1, 1, 0);
    run_scan(cfg(SCAN_ONCE, 4'h7, 1, 0, 0, 0), 7, 0, 1, 0);
    run_scan(cfg(SCAN_ONCE, 4'hb, 1, 1, 0, 0), 11, 0, 1, 1);
    run_scan(cfg(SCAN_UP, 4'h3, 0, 0, 0, 0), 1, 2, 2, 0);
    run_scan(cfg(SCAN_UP, 4'h2, 0, 0, 0, 0), 0, 2, 2, 0);
    chk(32'({conv_diff, neg_ch}), 32'h13);
    for (int s = 1; s < 4; s += 2)
    begin
      acc(1'b1, ADR_CONFIG, cfg(2'(s), 4'h4, 1, 0, 1, 0));
      acc(1'b1, ADR_CTRL, 32'h1);
      do acc(1'b0, ADR_STATUS, 32'h0); while (rdat[15:8] < 8'h3);
      acc(1'b1, ADR_CTRL, 32'h2);
      wait_idle();
      n = rdat[15:8];
      chk(32'(n >= 8'h3), 32'h1);
      for (int k = 0; k < n; k++)
        pop(4'h4, 1'b0);
      $display("stream test done");
    end
    // Auto-off reference is powered only while a scan runs
    acc(1'b1, ADR_CONFIG, cfg(SCAN_REPEAT, 4'h1, 1, 0, 0, 3'h4));
    acc(1'b1, ADR_CTRL, 32'h1);
    chk(32'(ref_v[2]), 32'h0);
    acc(1'b0, ADR_STATUS, 32'h0);
    chk(32'({rdat[0], ref_v[2]}), 32'h3);
    wait_idle();
    chk(32'(ref_v[2]), 32'h0);
    for (int k = 0; k < 8; k++)
      pop(4'h1, 1'b0);
    $display("auto-off reference test done");
    run_pair(4'h7, 2, 6, 2);
    run_pair(4'h4, 2, 6, 1);
    for (int r = 0; r < 8; r++)
    begin
      acc(1'b1, ADR_CONFIG, cfg(SCAN_ONCE, 4'h0, 1, 0, 0, 3'(r)));
      acc(1'b0, ADR_CONFIG, 32'h0);
      e = 3'(r);
      chk(rdat, cfg(SCAN_ONCE, 4'h0, 1, 0, 0, e));
      chk(32'(ref_v), 32'({e[2:1] == 2'h0, e[2:1] == 2'h1, e[2],
        e == 3'h5 || e[2:1] == 2'h3, e[2:1] == 2'h1, e[2:1] == 2'h3}));
    end
    $display("reference test done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
